// ==== src/hslcf_regs.svh ====
// Constants of the high-speed link command front: codes, statuses, timing
`ifndef HSLCF_REGS_SVH
`define HSLCF_REGS_SVH

// Command codes carried in the command byte
`define HSLCF_CMD_SET_MODE   8'h01
`define HSLCF_CMD_ENABLE     8'h02
`define HSLCF_CMD_DISABLE    8'h03
`define HSLCF_CMD_CHANGE     8'h06
`define HSLCF_CMD_FLUSH      8'h09
`define HSLCF_CMD_RESET_D    8'h0B
`define HSLCF_CMD_RESET_N    8'h9C
`define HSLCF_CMD_TX_CTRL    8'h10
`define HSLCF_CMD_TX_DATA    8'h11
`define HSLCF_CMD_RX         8'h13
`define HSLCF_CMD_RX_CONT    8'h14
`define HSLCF_CMD_TRACE      8'h2C
`define HSLCF_CMD_STOP_TRACE 8'h2D
`define HSLCF_CMD_WRAP       8'h2E
`define HSLCF_CMD_HALT       8'hF0
`define HSLCF_CMD_HALT_IMM   8'hF1
`define HSLCF_CMD_DUMP_NS    8'hF4
`define HSLCF_CMD_DUMP_ST    8'hF5

// Line select field bit positions
`define HSLCF_SEL_PORT_BIT   6
`define HSLCF_SEL_DIR_BIT    7

// Line addresses of the scanner pair, two per scanner
`define HSLCF_LINE_BASE      12'h404
`define HSLCF_LINE_LAST      12'h407
`define HSLCF_SCANNER_IDX    1'h0

// Status codes returned to the host
`define HSLCF_ST_OK          8'h00
`define HSLCF_ST_FRAME_END   8'h01
`define HSLCF_ST_RX_PART     8'h02
`define HSLCF_ST_DUMP_ST     8'h04
`define HSLCF_ST_REJECT      8'h80
`define HSLCF_ST_HW_ERR      8'hC0

// Set mode parameter layout
`define HSLCF_PRM_INT_CLK    0
`define HSLCF_PRM_RATE_LO    1
`define HSLCF_PRM_ADDR_LO    8
`define HSLCF_BCAST_ADDR     8'hFF

// Bit timing: internal back-to-back rates at a 125 MHz core clock
`define HSLCF_CLK_HZ         125000000
`define HSLCF_RATE0_BPS      245760
`define HSLCF_RATE1_BPS      1474560
`define HSLCF_RATE2_BPS      1843200
`define HSLCF_DIV0           (`HSLCF_CLK_HZ / `HSLCF_RATE0_BPS)
`define HSLCF_DIV1           (`HSLCF_CLK_HZ / `HSLCF_RATE1_BPS)
`define HSLCF_DIV2           (`HSLCF_CLK_HZ / `HSLCF_RATE2_BPS)

// Frame staging memory
`define HSLCF_BUF_AW         8
`define HSLCF_BUF_W          9
`define HSLCF_FRAME_MAX      16'hFFFF

`endif

// ==== src/hslcf_pkg.sv ====
// Types shared by the high-speed link command front
package hslcf_pkg;

	typedef enum logic [1:0] {
		HSLCF_RATE_LOW,
		HSLCF_RATE_MID,
		HSLCF_RATE_HIGH,
		HSLCF_RATE_RSVD
	} hslcf_rate_t;

	typedef enum logic [2:0] {
		HSLCF_IDLE,
		HSLCF_TX,
		HSLCF_RX,
		HSLCF_STAT,
		HSLCF_IRQ
	} hslcf_state_t;

endpackage : hslcf_pkg

// ==== src/hslcf_frame_buf.sv ====
// Frame staging memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module hslcf_frame_buf #(
	parameter int AW = 8,
	parameter int W  = 9
) (
	input  wire logic          core_clk,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [W-1:0]  wr_data,
	input  wire logic          rd_en,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [W-1:0]  rd_data
);
	logic [W-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge core_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule : hslcf_frame_buf
`default_nettype wire

// ==== src/hslcf_command_front.sv ====
// Command front of the high-speed link scanner: decode, line state, frame staging
//
// Notes on behaviour
// - Decode set mode 01, enable 02, disable 03, change 06, flush 09, resets 0B, 9C.
// - Accept frame commands transmit control 10, transmit data 11, receive 13, continue 14.
// - Decode trace 2C, stop trace 2D, halt F0, halt immediate F1, dumps F4, F5.
// - Wrap 2E is accepted only when issued from the maintenance console.
// - Bit 6 of the line select field picks one of the two lines.
// - Bit 7 of the line select field: zero transmit, one receive.
// - Only one of the two ports may be enabled at any time.
// - The lines answer as addresses 404 to 407, two per scanner.
// - On a network, bit timing follows the network clock, up to 2.048 Mbps.
// - Back to back, one of three host-selected internal rates is used.
// - Frames up to 64 kbytes long are handled.
// - Station address compare on received frames is done here, in hardware.
// - A received frame may span several receive operations.
// - Transmit continue and receive monitor are not implemented.
// - Frames are staged in this block's own buffers.
// - Frame data moves over the direct-memory side, not the processor.
// - Hardware errors send status first, then a level 2 interrupt.
// - No cycle stealing on the control bus for frame data.
// - Full-duplex point-to-point line, no multiplexing of lines.
`timescale 1ns/1ps
`default_nettype none
`include "hslcf_regs.svh"
module hslcf_command_front (
	input  wire logic                 core_clk,
	input  wire logic                 reset_variant_n,
	input  wire logic                 cmd_valid,
	output logic                      cmd_ready,
	input  wire logic [7:0]           cmd_code,
	input  wire logic [7:0]           cmd_line,
	input  wire logic [15:0]          cmd_param,
	input  wire logic                 cmd_console,
	output logic                      stat_valid,
	input  wire logic                 stat_ready,
	output logic [7:0]                stat_code,
	output logic [11:0]               stat_line,
	output logic                      lvl2_irq,
	input  wire logic                 err_fe,
	input  wire logic                 err_dma,
	input  wire logic                 err_sctl,
	input  wire logic                 dm_tx_valid,
	output logic                      dm_tx_ready,
	input  wire logic [7:0]           dm_tx_data,
	output logic                      dm_rx_valid,
	input  wire logic                 dm_rx_ready,
	output logic [7:0]                dm_rx_data,
	output logic                      dm_rx_last,
	input  wire logic                 line_clk_net,
	output logic                      ln_bit_en,
	output logic [1:0]                port_en,
	output logic                      trace_on,
	output logic                      wrap_on,
	output logic                      ln_tx_valid,
	input  wire logic                 ln_tx_ready,
	output logic [7:0]                ln_tx_byte,
	output logic                      ln_tx_last,
	input  wire logic                 ln_rx_valid,
	input  wire logic [7:0]           ln_rx_byte,
	input  wire logic                 ln_rx_last,
	output hslcf_pkg::hslcf_state_t   state
);
	import hslcf_pkg::*;

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	hslcf_state_t state_r;
	logic         line_en_r, act_port_r, int_clk_r, trace_r, wrap_r, err_pend_r;
	logic         partial_r, irq_after_r;
	hslcf_rate_t  rate_r;
	logic [7:0]   stn_addr_r, stat_code_r;
	logic [11:0]  stat_line_r;
	logic [15:0]  tx_cnt_r, rx_budget_r;

	wire       sel_port = cmd_line[`HSLCF_SEL_PORT_BIT];
	wire       sel_rx   = cmd_line[`HSLCF_SEL_DIR_BIT];
	wire       take     = cmd_valid && cmd_ready;
	wire       hw_err   = err_fe || err_dma || err_sctl;
	wire [11:0] sel_addr = `HSLCF_LINE_BASE + {10'h000, `HSLCF_SCANNER_IDX, sel_port};

	wire c_setm = (cmd_code == `HSLCF_CMD_SET_MODE) || (cmd_code == `HSLCF_CMD_CHANGE);
	wire c_en   = (cmd_code == `HSLCF_CMD_ENABLE);
	wire c_dis  = (cmd_code == `HSLCF_CMD_DISABLE);
	wire c_fl   = (cmd_code == `HSLCF_CMD_FLUSH);
	wire c_rst  = (cmd_code == `HSLCF_CMD_RESET_D) || (cmd_code == `HSLCF_CMD_RESET_N);
	wire c_tx   = (cmd_code == `HSLCF_CMD_TX_CTRL) || (cmd_code == `HSLCF_CMD_TX_DATA);
	wire c_rx   = (cmd_code == `HSLCF_CMD_RX);
	wire c_rxc  = (cmd_code == `HSLCF_CMD_RX_CONT);
	wire c_tr   = (cmd_code == `HSLCF_CMD_TRACE);
	wire c_str  = (cmd_code == `HSLCF_CMD_STOP_TRACE);
	wire c_hlt  = (cmd_code == `HSLCF_CMD_HALT);
	wire c_hlti = (cmd_code == `HSLCF_CMD_HALT_IMM);
	wire c_dmp  = (cmd_code == `HSLCF_CMD_DUMP_NS) || (cmd_code == `HSLCF_CMD_DUMP_ST);
	wire c_wrap = (cmd_code == `HSLCF_CMD_WRAP) && cmd_console;

	// Transmit continue and receive monitor simply fall outside this set
	wire known = c_setm || c_en || c_dis || c_fl || c_rst || c_tx || c_rx || c_rxc
		|| c_tr || c_str || c_hlt || c_hlti || c_dmp || c_wrap;
	wire on_line = line_en_r && (act_port_r == sel_port);
	// Second port stays off while the first is enabled
	wire en_bad  = c_en && line_en_r && (act_port_r != sel_port);
	wire tx_bad  = c_tx && (!on_line || sel_rx || (cmd_param == 16'h0000));
	wire rx_bad  = (c_rx || c_rxc) && (!on_line || !sel_rx || (cmd_param == 16'h0000));
	wire rxc_bad = c_rxc && !partial_r;
	wire reject  = !known || en_bad || tx_bad || rx_bad || rxc_bad;

	assign cmd_ready  = (state_r == HSLCF_IDLE) && !err_pend_r;
	assign stat_valid = (state_r == HSLCF_STAT);
	assign stat_code  = stat_code_r;
	assign stat_line  = stat_line_r;
	assign lvl2_irq   = (state_r == HSLCF_IRQ);
	assign state      = state_r;
	assign trace_on   = trace_r;
	assign wrap_on    = wrap_r;
	// One port only, never both lines at once
	assign port_en    = line_en_r ? (act_port_r ? 2'h2 : 2'h1) : 2'h0;

	// ----------------------------------------------------------------
	// Bit timing
	// ----------------------------------------------------------------
	logic [9:0] div_cnt_r;
	logic       net_clk_q_r;
	wire  [9:0] div_top = (rate_r == HSLCF_RATE_MID)  ? 10'(`HSLCF_DIV1 - 1) :
	                      (rate_r == HSLCF_RATE_HIGH) ? 10'(`HSLCF_DIV2 - 1) :
	                                                    10'(`HSLCF_DIV0 - 1);
	wire        int_tick = (div_cnt_r == div_top);
	// Network clock is a plain synchronous input; its rising edge is a bit slot
	wire        net_tick = line_clk_net && !net_clk_q_r;
	assign ln_bit_en = line_en_r && (int_clk_r ? int_tick : net_tick);

	always_ff @(posedge core_clk or negedge reset_variant_n) begin
		if (!reset_variant_n) begin
			div_cnt_r   <= 10'h000;
			net_clk_q_r <= 1'b0;
		end else begin
			div_cnt_r   <= int_tick ? 10'h000 : div_cnt_r + 10'h001;
			net_clk_q_r <= line_clk_net;
		end
	end

	// ----------------------------------------------------------------
	// Transmit staging ring
	// ----------------------------------------------------------------
	logic [7:0] tx_wp_r, tx_rp_r;
	logic [8:0] tx_lvl_r;
	logic       tx_pend_r, tx_out_r;
	logic [8:0] tx_rd;
	wire        tx_flush = take && (c_hlti || c_rst);
	assign dm_tx_ready = (state_r == HSLCF_TX) && (tx_lvl_r != 9'h100);
	wire        tx_wr    = dm_tx_valid && dm_tx_ready;
	wire        tx_issue = !tx_flush && (tx_lvl_r != 9'h000) && !tx_pend_r
		&& (!tx_out_r || ln_tx_ready);
	assign ln_tx_valid = tx_out_r;
	assign ln_tx_byte  = tx_rd[7:0];
	assign ln_tx_last  = tx_rd[8];

	always_ff @(posedge core_clk or negedge reset_variant_n) begin
		if (!reset_variant_n) begin
			tx_wp_r <= 8'h00;
			tx_rp_r <= 8'h00;
			tx_lvl_r <= 9'h000;
			tx_pend_r <= 1'b0;
			tx_out_r <= 1'b0;
		end else if (tx_flush) begin
			tx_wp_r <= 8'h00;
			tx_rp_r <= 8'h00;
			tx_lvl_r <= 9'h000;
			tx_pend_r <= 1'b0;
			tx_out_r <= 1'b0;
		end else begin
			tx_wp_r  <= tx_wp_r + {7'h00, tx_wr};
			tx_rp_r  <= tx_rp_r + {7'h00, tx_issue};
			tx_lvl_r <= tx_lvl_r + {8'h00, tx_wr} - {8'h00, tx_issue};
			tx_pend_r <= tx_issue;
			tx_out_r  <= tx_pend_r || (tx_out_r && !ln_tx_ready);
		end
	end

	// Staged in local memory, not in processor storage
	hslcf_frame_buf #(.AW(`HSLCF_BUF_AW), .W(`HSLCF_BUF_W)) u_tx_buf (
		.core_clk (core_clk),
		.wr_en    (tx_wr),
		.wr_addr  (tx_wp_r),
		.wr_data  ({tx_cnt_r == 16'h0001, dm_tx_data}),
		.rd_en    (tx_issue),
		.rd_addr  (tx_rp_r),
		.rd_data  (tx_rd)
	);

	// ----------------------------------------------------------------
	// Receive staging ring with station address filter
	// ----------------------------------------------------------------
	logic [7:0]  rx_wp_r, rx_rp_r;
	logic [8:0]  rx_lvl_r;
	logic        rx_pend_r, rx_out_r, rx_first_r, rx_drop_r;
	logic [15:0] rx_len_r;
	logic [8:0]  rx_rd;
	wire         rx_flush = take && (c_fl || c_rst);
	// First byte of a frame is the station address; broadcast always passes
	wire addr_miss = rx_first_r && (ln_rx_byte != stn_addr_r)
		&& (ln_rx_byte != `HSLCF_BCAST_ADDR);
	wire too_long  = (rx_len_r == `HSLCF_FRAME_MAX);
	wire rx_keep   = ln_rx_valid && line_en_r && !rx_drop_r && !addr_miss && !too_long;
	wire rx_ovr    = rx_keep && (rx_lvl_r == 9'h100);
	wire rx_wr     = rx_keep && !rx_ovr && !rx_flush;
	wire rx_take   = dm_rx_valid && dm_rx_ready;
	wire rx_issue  = !rx_flush && (state_r == HSLCF_RX) && (rx_lvl_r != 9'h000)
		&& !rx_pend_r && !rx_out_r && (rx_budget_r != 16'h0000);
	assign dm_rx_valid = rx_out_r;
	assign dm_rx_data  = rx_rd[7:0];
	assign dm_rx_last  = rx_rd[8];

	always_ff @(posedge core_clk or negedge reset_variant_n) begin
		if (!reset_variant_n) begin
			rx_wp_r <= 8'h00;
			rx_rp_r <= 8'h00;
			rx_lvl_r <= 9'h000;
			rx_pend_r <= 1'b0;
			rx_out_r <= 1'b0;
			rx_first_r <= 1'b1;
			rx_drop_r <= 1'b0;
			rx_len_r <= 16'h0000;
		end else if (rx_flush) begin
			rx_wp_r <= 8'h00;
			rx_rp_r <= 8'h00;
			rx_lvl_r <= 9'h000;
			rx_pend_r <= 1'b0;
			rx_out_r <= 1'b0;
			rx_first_r <= 1'b1;
			rx_drop_r <= 1'b0;
			rx_len_r <= 16'h0000;
		end else begin
			rx_wp_r  <= rx_wp_r + {7'h00, rx_wr};
			rx_rp_r  <= rx_rp_r + {7'h00, rx_issue};
			rx_lvl_r <= rx_lvl_r + {8'h00, rx_wr} - {8'h00, rx_issue};
			rx_pend_r <= rx_issue;
			rx_out_r  <= rx_pend_r || (rx_out_r && !dm_rx_ready);
			if (ln_rx_valid) begin
				rx_first_r <= ln_rx_last;
				rx_drop_r  <= !ln_rx_last && (rx_drop_r || addr_miss || too_long || rx_ovr);
				rx_len_r   <= ln_rx_last ? 16'h0000 : rx_len_r + 16'h0001;
			end
		end
	end

	hslcf_frame_buf #(.AW(`HSLCF_BUF_AW), .W(`HSLCF_BUF_W)) u_rx_buf (
		.core_clk (core_clk),
		.wr_en    (rx_wr),
		.wr_addr  (rx_wp_r),
		.wr_data  ({ln_rx_last, ln_rx_byte}),
		.rd_en    (rx_issue),
		.rd_addr  (rx_rp_r),
		.rd_data  (rx_rd)
	);

	// ----------------------------------------------------------------
	// Control state machine
	// ----------------------------------------------------------------
	hslcf_state_t state_nxt;
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			HSLCF_IDLE: begin
				if (err_pend_r) begin
					state_nxt = HSLCF_STAT;
				end else if (take && !reject && c_tx) begin
					state_nxt = HSLCF_TX;
				end else if (take && !reject && (c_rx || c_rxc)) begin
					state_nxt = HSLCF_RX;
				end else if (take) begin
					state_nxt = HSLCF_STAT;
				end
			end
			HSLCF_TX: begin
				if (tx_wr && (tx_cnt_r == 16'h0001)) begin
					state_nxt = HSLCF_STAT;
				end
			end
			HSLCF_RX: begin
				if (rx_take && (dm_rx_last || (rx_budget_r == 16'h0000))) begin
					state_nxt = HSLCF_STAT;
				end
			end
			HSLCF_STAT: begin
				if (stat_ready) begin
					state_nxt = irq_after_r ? HSLCF_IRQ : HSLCF_IDLE;
				end
			end
			HSLCF_IRQ: state_nxt = HSLCF_IDLE;
			default:   state_nxt = HSLCF_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_variant_n) begin
		if (!reset_variant_n) begin
			state_r <= HSLCF_IDLE;
			line_en_r <= 1'b0;
			act_port_r <= 1'b0;
			int_clk_r <= 1'b0;
			rate_r <= HSLCF_RATE_LOW;
			stn_addr_r <= 8'h00;
			trace_r <= 1'b0;
			wrap_r <= 1'b0;
			err_pend_r <= 1'b0;
			partial_r <= 1'b0;
			irq_after_r <= 1'b0;
			stat_code_r <= `HSLCF_ST_OK;
			stat_line_r <= `HSLCF_LINE_BASE;
			tx_cnt_r <= 16'h0000;
			rx_budget_r <= 16'h0000;
		end else begin
			state_r <= state_nxt;
			// New error wins over the clear made when idle loads its status
			if (hw_err || rx_ovr) begin
				err_pend_r <= 1'b1;
			end else if (state_r == HSLCF_IDLE && err_pend_r) begin
				err_pend_r <= 1'b0;
			end
			if (state_r == HSLCF_IDLE && err_pend_r) begin
				stat_code_r <= `HSLCF_ST_HW_ERR;
				irq_after_r <= 1'b1;
			end else if (take) begin
				stat_line_r <= sel_addr;
				irq_after_r <= 1'b0;
				stat_code_r <= reject ? `HSLCF_ST_REJECT :
					(cmd_code == `HSLCF_CMD_DUMP_ST) ? `HSLCF_ST_DUMP_ST : `HSLCF_ST_OK;
				if (!reject) begin
					if (c_setm) begin
						int_clk_r  <= cmd_param[`HSLCF_PRM_INT_CLK];
						rate_r     <= hslcf_rate_t'(cmd_param[`HSLCF_PRM_RATE_LO +: 2]);
						stn_addr_r <= cmd_param[`HSLCF_PRM_ADDR_LO +: 8];
					end
					if (c_en) begin
						line_en_r  <= 1'b1;
						act_port_r <= sel_port;
					end
					if ((c_dis && on_line) || c_rst || c_hlt || c_hlti) begin
						line_en_r <= 1'b0;
						wrap_r    <= 1'b0;
					end
					if (c_tr || c_str) begin
						trace_r <= c_tr;
					end
					if (c_wrap) begin
						wrap_r <= 1'b1;
					end
					if (c_fl || c_rst || c_rx) begin
						partial_r <= 1'b0;
					end
					tx_cnt_r    <= c_tx ? cmd_param : tx_cnt_r;
					rx_budget_r <= (c_rx || c_rxc) ? cmd_param : rx_budget_r;
				end
			end else begin
				if (tx_wr) begin
					tx_cnt_r <= tx_cnt_r - 16'h0001;
				end
				if (rx_issue) begin
					rx_budget_r <= rx_budget_r - 16'h0001;
				end
				if (rx_take) begin
					// Budget spent mid-frame: the next receive continue picks it up
					partial_r   <= !dm_rx_last;
					stat_code_r <= dm_rx_last ? `HSLCF_ST_FRAME_END : `HSLCF_ST_RX_PART;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_variant_n);

	sequence s_err_status;
		state_r == HSLCF_STAT && stat_code_r == `HSLCF_ST_HW_ERR && stat_ready;
	endsequence
	sequence s_bad_take;
		take && (!known || rxc_bad);
	endsequence

	a_reject_answer: assert property (s_bad_take |=>
		state_r == HSLCF_STAT && stat_code_r == `HSLCF_ST_REJECT)
		else $error("unsupported command not rejected");
	a_wrap_source: assert property (take && cmd_code == `HSLCF_CMD_WRAP && !cmd_console
		|=> stat_code_r == `HSLCF_ST_REJECT && !$rose(wrap_r))
		else $error("wrap taken from host program");
	a_single_port: assert property (port_en != 2'h3)
		else $error("both ports enabled");
	a_err_then_irq: assert property (s_err_status |=> lvl2_irq ##1 !lvl2_irq)
		else $error("level 2 interrupt missing after error status");
	a_line_range: assert property (stat_valid |->
		stat_line_r >= `HSLCF_LINE_BASE && stat_line_r <= `HSLCF_LINE_LAST)
		else $error("line address out of range");
	a_tx_dir_check: assert property (take && c_tx && sel_rx |=>
		state_r == HSLCF_STAT && stat_code_r == `HSLCF_ST_REJECT)
		else $error("transmit accepted on receive interface");
	a_rx_partial: assert property (rx_take && !dm_rx_last && rx_budget_r == 16'h0000
		|=> partial_r && stat_code_r == `HSLCF_ST_RX_PART)
		else $error("partial frame not kept for continue");
	a_addr_filter: assert property (ln_rx_valid && addr_miss |-> !rx_wr)
		else $error("foreign station frame stored");
	a_enable_port: assert property (take && c_en && !reject |=>
		line_en_r && act_port_r == $past(sel_port))
		else $error("enable did not select the addressed port");
	a_bit_pacing: assert property (line_en_r && int_clk_r && ln_bit_en
		&& $stable(rate_r) |=> !ln_bit_en [*8])
		else $error("internal bit enable too fast");
endmodule : hslcf_command_front
`default_nettype wire

// ==== tb/hslcf_host_model.sv ====
// Host model: issues one command when send is set, then collects one status word
`timescale 1ns/1ps
`default_nettype none
module hslcf_host_model (
	input  wire logic        core_clk,
	input  wire logic        reset_variant_n,
	input  wire logic        go,
	input  wire logic        send,
	input  wire logic [7:0]  code,
	input  wire logic [7:0]  line,
	input  wire logic [15:0] param,
	input  wire logic        console,
	output var logic         done,
	output var logic  [7:0]  got_code,
	output var logic  [11:0] got_line,
	output var logic         cmd_valid,
	input  wire logic        cmd_ready,
	output var logic  [7:0]  cmd_code,
	output var logic  [7:0]  cmd_line,
	output var logic  [15:0] cmd_param,
	output var logic         cmd_console,
	input  wire logic        stat_valid,
	output var logic         stat_ready,
	input  wire logic [7:0]  stat_code,
	input  wire logic [11:0] stat_line
);
	logic [1:0] st_r;

	// Without send only a status is awaited, as after a hardware error
	always_ff @(posedge core_clk or negedge reset_variant_n) begin
		if (!reset_variant_n) begin
			st_r <= 2'h0;
			cmd_valid <= 1'b0;
			stat_ready <= 1'b0;
			done <= 1'b0;
			got_code <= 8'h00;
			got_line <= 12'h000;
		end else begin
			case (st_r)
				2'h0: if (go) begin
					cmd_code <= code;
					cmd_line <= line;
					cmd_param <= param;
					cmd_console <= console;
					cmd_valid <= send;
					stat_ready <= !send;
					done <= 1'b0;
					st_r <= send ? 2'h1 : 2'h2;
				end
				2'h1: if (cmd_ready) begin
					cmd_valid <= 1'b0;
					cmd_code <= ~cmd_code;
					stat_ready <= 1'b1;
					st_r <= 2'h2;
				end
				default: if (stat_valid) begin
					got_code <= stat_code;
					got_line <= stat_line;
					stat_ready <= 1'b0;
					done <= 1'b1;
					st_r <= 2'h0;
				end
			endcase
		end
	end
endmodule : hslcf_host_model
`default_nettype wire

// ==== tb/hslcf_command_front_tb.sv ====
// Self-checking bench of the high-speed link command front
`timescale 1ns/1ps
`default_nettype none
module hslcf_command_front_tb;
	typedef struct packed {
		logic [7:0]  code;
		logic [7:0]  line;
		logic [15:0] param;
		logic        con;
		logic [7:0]  st;
		logic [2:0]  pe;
	} hslcf_row_t;
	logic core_clk, reset_variant_n, go, h_send, h_con, done, cmd_valid, cmd_ready, cmd_console;
	logic stat_valid, stat_ready, lvl2_irq, err_fe, err_dma, err_sctl, dm_tx_valid, dm_tx_ready;
	logic dm_rx_valid, dm_rx_ready, dm_rx_last, line_clk_net, ln_bit_en, trace_on, wrap_on;
	logic ln_tx_valid, ln_tx_ready, ln_tx_last, ln_rx_valid, ln_rx_last;
	logic [7:0] h_code, h_line, got_code, cmd_code, cmd_line, stat_code, dm_tx_data, dm_rx_data;
	logic [7:0] ln_tx_byte, ln_rx_byte;
	logic [15:0] h_param, cmd_param;
	logic [11:0] got_line, stat_line, rx_seen;
	logic [1:0] port_en;
	int num_errors, checks, n;
	hslcf_row_t rows [0:21];

	hslcf_host_model host (.core_clk(core_clk), .reset_variant_n(reset_variant_n), .go(go), .send(h_send),
		.code(h_code), .line(h_line), .param(h_param), .console(h_con), .done(done),
		.got_code(got_code), .got_line(got_line), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_code(cmd_code), .cmd_line(cmd_line), .cmd_param(cmd_param),
		.cmd_console(cmd_console), .stat_valid(stat_valid), .stat_ready(stat_ready),
		.stat_code(stat_code), .stat_line(stat_line));
	hslcf_command_front dut (.core_clk(core_clk), .reset_variant_n(reset_variant_n), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_line(cmd_line), .cmd_param(cmd_param),
		.cmd_console(cmd_console), .stat_valid(stat_valid), .stat_ready(stat_ready),
		.stat_code(stat_code), .stat_line(stat_line), .lvl2_irq(lvl2_irq), .err_fe(err_fe),
		.err_dma(err_dma), .err_sctl(err_sctl), .dm_tx_valid(dm_tx_valid),
		.dm_tx_ready(dm_tx_ready), .dm_tx_data(dm_tx_data), .dm_rx_valid(dm_rx_valid),
		.dm_rx_ready(dm_rx_ready), .dm_rx_data(dm_rx_data), .dm_rx_last(dm_rx_last),
		.line_clk_net(line_clk_net), .ln_bit_en(ln_bit_en), .port_en(port_en),
		.trace_on(trace_on), .wrap_on(wrap_on), .ln_tx_valid(ln_tx_valid),
		.ln_tx_ready(ln_tx_ready), .ln_tx_byte(ln_tx_byte), .ln_tx_last(ln_tx_last),
		.ln_rx_valid(ln_rx_valid), .ln_rx_byte(ln_rx_byte), .ln_rx_last(ln_rx_last), .state());

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		if (dm_rx_valid && dm_rx_ready) rx_seen <= {3'h0, dm_rx_last, dm_rx_data};
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic end_of_test;
		$display("checks=%0d mismatches=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_of_test

	task automatic issue(input logic [7:0] c, l, input logic [15:0] p, input logic k, s);
		@(posedge core_clk);
		h_code <= c;
		h_line <= l;
		h_param <= p;
		h_con <= k;
		h_send <= s;
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
	endtask : issue

	task automatic rx_in(input logic [7:0] b, input logic l);
		@(posedge core_clk);
		ln_rx_byte <= b;
		ln_rx_last <= l;
		ln_rx_valid <= 1'b1;
		@(posedge core_clk);
		ln_rx_valid <= 1'b0;
	endtask : rx_in

	// Sampled mid-cycle so registered outputs have settled
	task automatic wait_done;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (!done && n < 300);
		if (!done) begin
			num_errors++;
			end_of_test();
		end
	endtask : wait_done

	task automatic do_reset;
		reset_variant_n <= 1'b0;
		repeat (8) @(posedge core_clk);
		reset_variant_n <= 1'b1;
	endtask : do_reset

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{reset_variant_n, go, h_send, h_con, err_fe, err_dma, err_sctl, dm_tx_valid, ln_rx_valid} = '0;
		{ln_rx_last, line_clk_net} = '0;
		{h_code, h_line, dm_tx_data, ln_rx_byte, h_param} = '0;
		{dm_rx_ready, ln_tx_ready} = 2'h3;
		num_errors = 0;
		checks = 0;
		// code, line, param, console, status, wrap enable and port enables
		rows = '{'{8'h01, 8'h00, 16'h0000, 1'h0, 8'h00, 3'h0}, '{8'h01, 8'h00, 16'h0003, 1'h0, 8'h00, 3'h0},
			'{8'h01, 8'h00, 16'h0005, 1'h0, 8'h00, 3'h0}, '{8'h2C, 8'h00, 16'h0000, 1'h0, 8'h00, 3'h0},
			'{8'h2D, 8'h00, 16'h0000, 1'h0, 8'h00, 3'h0}, '{8'h12, 8'h00, 16'h0001, 1'h0, 8'h80, 3'h0},
			'{8'h15, 8'h80, 16'h0001, 1'h0, 8'h80, 3'h0}, '{8'h55, 8'h00, 16'h0000, 1'h0, 8'h80, 3'h0},
			'{8'h2E, 8'h00, 16'h0000, 1'h0, 8'h80, 3'h0}, '{8'h2E, 8'h00, 16'h0000, 1'h1, 8'h00, 3'h4},
			'{8'h02, 8'h00, 16'h0000, 1'h0, 8'h00, 3'h5}, '{8'h02, 8'h40, 16'h0000, 1'h0, 8'h80, 3'h5},
			'{8'h11, 8'h40, 16'h0001, 1'h0, 8'h80, 3'h5}, '{8'h11, 8'h80, 16'h0001, 1'h0, 8'h80, 3'h5},
			'{8'h14, 8'h80, 16'h0001, 1'h0, 8'h80, 3'h5}, '{8'h06, 8'h00, 16'h0000, 1'h0, 8'h00, 3'h5},
			'{8'hF4, 8'h00, 16'h0000, 1'h0, 8'h00, 3'h5}, '{8'hF5, 8'h00, 16'h0000, 1'h0, 8'h04, 3'h5},
			'{8'h03, 8'h00, 16'h0000, 1'h0, 8'h00, 3'h0}, '{8'h02, 8'h40, 16'h0000, 1'h0, 8'h00, 3'h2},
			'{8'hF0, 8'h40, 16'h0000, 1'h0, 8'h00, 3'h0}, '{8'hF1, 8'h40, 16'h0000, 1'h0, 8'h00, 3'h0}};
		reset_variant_n <= 1'b0;
		repeat (4) @(negedge core_clk);
		chk({cmd_ready, stat_valid, lvl2_irq, port_en, stat_code}, 16'h1000);
		chk(stat_line, 12'h404);
		do_reset();
		$display("test reset done");
		foreach (rows[i]) begin
			issue(rows[i].code, rows[i].line, rows[i].param, rows[i].con, 1'b1);
			wait_done();
			chk(got_code, rows[i].st);
			chk(got_line, 12'h404 + rows[i].line[6]);
			chk({wrap_on, port_en}, rows[i].pe);
		end
		$display("test command table done");
		issue(8'h2C, 8'h00, 16'h0000, 1'b0, 1'b1);
		wait_done();
		chk(trace_on, 1'b1);
		issue(8'h09, 8'h40, 16'h0000, 1'b0, 1'b1);
		wait_done();
		chk(got_code, 8'h00);
		issue(8'h0B, 8'h40, 16'h0000, 1'b0, 1'b1);
		wait_done();
		chk(got_code, 8'h00);
		issue(8'h9C, 8'h40, 16'h0000, 1'b0, 1'b1);
		wait_done();
		chk(got_code, 8'h00);
		do_reset();
		issue(8'h02, 8'h00, 16'h0000, 1'b0, 1'b1);
		wait_done();
		// One frame of one byte, with the line side ready
		issue(8'h11, 8'h00, 16'h0001, 1'b0, 1'b1);
		dm_tx_data <= 8'hA5;
		dm_tx_valid <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (!dm_tx_ready && n < 50);
		dm_tx_valid <= 1'b0;
		if (!dm_tx_ready) num_errors++;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (!ln_tx_valid && n < 50);
		chk({ln_tx_valid, ln_tx_last, ln_tx_byte}, 12'h3A5);
		wait_done();
		chk(got_code, 8'h00);
		$display("test transmit done");
		@(posedge core_clk);
		line_clk_net <= 1'b1;
		@(negedge core_clk);
		chk(ln_bit_en, 1'b1);
		@(negedge core_clk);
		chk(ln_bit_en, 1'b0);
		// Foreign station frame first, then one of ours over two receive operations
		rx_in(8'h77, 1'b1);
		rx_in(8'h00, 1'b0);
		rx_in(8'h5A, 1'b0);
		rx_in(8'h3C, 1'b1);
		issue(8'h13, 8'h80, 16'h0002, 1'b0, 1'b1);
		wait_done();
		chk(got_code, 8'h02);
		chk(rx_seen, 12'h05A);
		issue(8'h14, 8'h80, 16'h0001, 1'b0, 1'b1);
		wait_done();
		chk(got_code, 8'h01);
		chk(rx_seen, 12'h13C);
		$display("test receive done");
		for (int e = 0; e < 3; e++) begin
			issue(8'h00, 8'h00, 16'h0000, 1'b0, 1'b0);
			{err_sctl, err_dma, err_fe} <= 3'h1 << e;
			@(posedge core_clk);
			{err_sctl, err_dma, err_fe} <= 3'h0;
			wait_done();
			chk(got_code, 8'hC0);
			chk(lvl2_irq, 1'b1);
			@(negedge core_clk);
			chk(lvl2_irq, 1'b0);
		end
		$display("test errors done");
		end_of_test();
	end
endmodule : hslcf_command_front_tb
`default_nettype wire
